// File: verilog/lif_tx_regs.vh
// register map, field positions, reset values and timing counts
// Function
// - software mode: standard bit 0 selects E1, 1 selects T1/J1.
// - hardware mode: template pins give standard, template and termination.
// - flag and interrupt when line clock is missing over 70 clocks.
// - software mode: edge select and data invert bits steer sampling.
// - hardware mode: sample on falling edge, data active high.
// - upper mode bit 0 single-rail one pin, 1 dual-rail two pins.
// - single-rail T1/J1 encodes B8ZS or AMI by lower mode bit.
// - single-rail E1 encodes HDB3 or AMI by lower mode bit.
// - dual-rail bypasses the encoder, rails go straight to pulses.
// - dual-rail: positive rail gives negative pulse, opposite positive.
// - hardware mode: path mode pins set the path operating mode.
// - T1 offers five short-haul templates via template field.
// - long haul offers four attenuation grades via template field.
// - template code 11xx shapes pulses from the waveform memory.
// - waveform memory holds 64 entries: 2-bit interval, 4-bit sample.
// - each sample is 7-bit signed magnitude, +63 to -63.
// - access: set indices, write data, set direction, set done.
// - arbitrary waveform amplitude scaled by 6-bit scale field.
// - converter overflow sets status bit, interrupt if mask enables.
// - no scaling for preset templates or line build-out.
// - control mode pins 00 select hardware control, else software.
`ifndef LIF_TX_REGS_VH
`define LIF_TX_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LIF_OFS_GLOBAL_CONFIG   8'h02
`define LIF_OFS_TX_CONFIG_0     8'h05
`define LIF_OFS_TX_CONFIG_1     8'h06
`define LIF_OFS_TX_AMP_SCALE    8'h07
`define LIF_OFS_WAVE_RAM_CTRL   8'h08
`define LIF_OFS_WAVE_RAM_DATA   8'h09
`define LIF_OFS_INT_MASK_1      8'h15
`define LIF_OFS_INT_STATUS_1    8'h1a

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LIF_BIT_LINE_STD        0
`define LIF_BIT_MODE_LO         0
`define LIF_BIT_MODE_HI         1
`define LIF_BIT_DATA_INV        2
`define LIF_BIT_EDGE_SEL        3
`define LIF_BIT_RAM_RW          6
`define LIF_BIT_RAM_DONE        7
`define LIF_BIT_DAC_OV          0
`define LIF_BIT_CLK_LOSS        1

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define LIF_RST_SCALE           6'h21
`define LIF_RST_TEMPLATE        4'h0
`define LIF_RST_CFG0            4'h0
`define LIF_RST_MASK            2'h0
`define LIF_CLK_LOSS_CYCLES     70
`define LIF_HW_MODE_CODE        2'h0

`endif

// File: verilog/lif_tx_front.v
// transmit path front end: sampling, line coding, waveform memory, shaping
`timescale 1ns/1ps
`default_nettype none
`include "lif_tx_regs.vh"

module lif_tx_front #(
    parameter SUBPHASE_CYCLES = 4
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_reset_n,
    // register port
    input  wire [7:0]  i_reg_addr,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    input  wire [7:0]  i_reg_wdata,
    output reg  [7:0]  o_reg_rdata,
    // system side transmit interface
    input  wire        i_tx_line_clock,
    input  wire        i_tx_data_positive,
    input  wire        i_tx_data_negative,
    // hardware strap pins
    input  wire [1:0]  i_control_mode,
    input  wire [3:0]  i_pulse_template_select,
    input  wire [1:0]  i_path_mode_pins,
    // line side
    output reg         o_line_pos,
    output reg         o_line_neg,
    output reg  [6:0]  o_wave_sample,
    output wire [3:0]  o_template_select,
    output wire        o_line_standard,
    output wire        o_term_internal,
    output wire [1:0]  o_path_mode,
    output wire        o_irq
);

    // ------------------------------------------------------------
    // symbols and encoder patterns
    // ------------------------------------------------------------
    localparam [1:0] SYM_SP = 2'h0;
    localparam [1:0] SYM_B  = 2'h1;
    localparam [1:0] SYM_V  = 2'h2;
    localparam [15:0] PAT_B8ZS = {SYM_SP, SYM_SP, SYM_SP, SYM_V,
                                  SYM_B, SYM_SP, SYM_V, SYM_B};
    localparam integer LOSS_LIM = `LIF_CLK_LOSS_CYCLES;
    localparam integer SUB_LIM  = SUBPHASE_CYCLES - 1;
    localparam [6:0]   LOSS_MAX = LOSS_LIM[6:0];
    localparam [7:0]   SUB_LAST = SUB_LIM[7:0];

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg  [10:0] sync1_ff;
    reg  [10:0] sync2_ff;
    reg         clk_dly_ff;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_ff   <= 11'h000;
            sync2_ff   <= 11'h000;
            clk_dly_ff <= 1'b0;
        end else begin
            sync1_ff   <= {i_tx_line_clock, i_tx_data_positive,
                           i_tx_data_negative, i_control_mode,
                           i_pulse_template_select, i_path_mode_pins};
            sync2_ff   <= sync1_ff;
            clk_dly_ff <= sync2_ff[10];
        end
    end

    wire       clk_s   = sync2_ff[10];
    wire       prail_s = sync2_ff[9];
    wire       nrail_s = sync2_ff[8];
    wire [1:0] mode_s  = sync2_ff[7:6];
    wire [3:0] tpl_s   = sync2_ff[5:2];
    wire [1:0] path_s  = sync2_ff[1:0];

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    reg        std_ff;
    reg  [3:0] cfg0_ff;
    reg  [3:0] tmpl_ff;
    reg  [5:0] scale_ff;
    reg  [5:0] ram_addr_ff;
    reg        ram_rw_ff;
    reg        ram_done_ff;
    reg  [6:0] wval_ff;
    reg  [1:0] mask_ff;
    reg  [1:0] stat_ff;
    reg  [6:0] ram_ff [0:63];
    integer    i;

    wire hw_mode = (mode_s == `LIF_HW_MODE_CODE);
    // effective controls: straps or fixed defaults in hardware mode, registers otherwise
    wire       eff_std  = hw_mode ? (tpl_s[3:1] != 3'h0)
                                  : std_ff;
    wire [3:0] eff_tmpl = hw_mode ? tpl_s : tmpl_ff;
    wire [1:0] eff_mode = hw_mode ? path_s : cfg0_ff[1:0];
    wire       eff_inv  = hw_mode ? 1'b0
                                  : cfg0_ff[`LIF_BIT_DATA_INV];
    wire       eff_rise = hw_mode ? 1'b0
                                  : cfg0_ff[`LIF_BIT_EDGE_SEL];
    wire       dual     = eff_mode[`LIF_BIT_MODE_HI];
    wire       ami      = eff_mode[`LIF_BIT_MODE_LO];
    // preset short-haul and build-out codes only go to the analog shaper
    wire       arb_mode = (eff_tmpl[3:2] == 2'h3);

    assign o_template_select = eff_tmpl;
    assign o_line_standard   = eff_std;
    // code 0001 in hardware mode means matching is done off chip
    assign o_term_internal   = hw_mode ? (tpl_s != 4'h1) : 1'b1;
    assign o_path_mode       = eff_mode;

    // ------------------------------------------------------------
    // line clock edge and loss detection
    // ------------------------------------------------------------
    wire rise     = clk_s & ~clk_dly_ff;
    wire fall     = ~clk_s & clk_dly_ff;
    wire bit_tick = eff_rise ? rise : fall;
    wire dp       = prail_s ^ eff_inv;
    wire dn       = nrail_s ^ eff_inv;

    reg  [6:0] loss_cnt_ff;
    wire       loss_set = (loss_cnt_ff == LOSS_MAX) & ~rise & ~fall;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            loss_cnt_ff <= 7'h00;
        end else if (rise | fall) begin
            loss_cnt_ff <= 7'h00;
        end else if (loss_cnt_ff <= LOSS_MAX) begin
            // one flag event per outage; counter parks above the limit
            loss_cnt_ff <= loss_cnt_ff + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // line encoder: eight-symbol look-behind pipeline
    // ------------------------------------------------------------
    reg  [15:0] pipe_ff;
    reg  [15:0] nxt_pipe;
    reg         par_ff;
    reg         nxt_par;
    reg         last_pos_ff;
    reg         nxt_last_pos;
    reg         nxt_pos;
    reg         nxt_neg;

    always @* begin
        nxt_pipe = {pipe_ff[13:0], (dp ? SYM_B : SYM_SP)};
        nxt_par  = par_ff ^ dp;
        if (!dual && !ami && eff_std && nxt_pipe == 16'h0000) begin
            nxt_pipe = PAT_B8ZS;
        end
        if (!dual && !ami && !eff_std && nxt_pipe[7:0] == 8'h00) begin
            // odd mark count since last violation needs no balancing mark
            nxt_pipe[7:0] = par_ff ? {SYM_SP, SYM_SP, SYM_SP, SYM_V}
                                   : {SYM_B, SYM_SP, SYM_SP, SYM_V};
            nxt_par       = 1'b0;
        end
    end

    always @* begin
        nxt_last_pos = last_pos_ff;
        nxt_pos      = 1'b0;
        nxt_neg      = 1'b0;
        if (dual) begin
            nxt_pos = dn & ~dp;
            nxt_neg = dp & ~dn;
        end else begin
            case (pipe_ff[15:14])
                SYM_B: begin
                    nxt_pos      = ~last_pos_ff;
                    nxt_neg      = last_pos_ff;
                    nxt_last_pos = ~last_pos_ff;
                end
                SYM_V: begin
                    nxt_pos = last_pos_ff;
                    nxt_neg = ~last_pos_ff;
                end
                default: begin
                    nxt_pos = 1'b0;
                    nxt_neg = 1'b0;
                end
            endcase
        end
    end

    reg  [7:0] hist_ff;
    reg  [3:0] phase_ff;
    reg  [7:0] sub_cnt_ff;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pipe_ff     <= 16'h0000;
            par_ff      <= 1'b0;
            last_pos_ff <= 1'b0;
            o_line_pos  <= 1'b0;
            o_line_neg  <= 1'b0;
            hist_ff     <= 8'h00;
            phase_ff    <= 4'h0;
            sub_cnt_ff  <= 8'h00;
        end else if (bit_tick) begin
            pipe_ff     <= dual ? 16'h0000 : nxt_pipe;
            par_ff      <= dual ? 1'b0 : nxt_par;
            last_pos_ff <= nxt_last_pos;
            o_line_pos  <= nxt_pos;
            o_line_neg  <= nxt_neg;
            hist_ff     <= {hist_ff[5:0], nxt_pos, nxt_neg};
            phase_ff    <= 4'h0;
            sub_cnt_ff  <= 8'h00;
        end else if (sub_cnt_ff == SUB_LAST) begin
            sub_cnt_ff  <= 8'h00;
            if (phase_ff != 4'hf) begin
                phase_ff <= phase_ff + 4'h1;
            end
        end else begin
            sub_cnt_ff  <= sub_cnt_ff + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // arbitrary waveform sum, scale and saturate
    // ------------------------------------------------------------
    integer    k;
    integer    sum;
    integer    scaled;
    integer    mag;
    reg  [6:0] smp;
    reg  [6:0] nxt_wave;
    reg        ovf;

    // overlapping intervals add; overflow can arise from that sum or from a scale above 32
    always @* begin
        sum      = 0;
        scaled   = 0;
        mag      = 0;
        smp      = 7'h00;
        nxt_wave = 7'h00;
        ovf      = 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
            smp = ram_ff[{k[1:0], phase_ff}];
            if (hist_ff[2*k+1] | hist_ff[2*k]) begin
                if (smp[6] ^ hist_ff[2*k]) begin
                    sum = sum - smp[5:0];
                end else begin
                    sum = sum + smp[5:0];
                end
            end
        end
        // default scale 33 over 32 is near unity, about 3 percent a step
        // scale kept signed so negative sums shift arithmetically
        scaled = (sum * $signed({1'b0, scale_ff})) >>> 5;
        mag    = (scaled < 0) ? -scaled : scaled;
        if (mag > 63) begin
            mag = 63;
            ovf = 1'b1;
        end
        nxt_wave = {(scaled < 0), mag[5:0]};
    end

    wire ovf_set = arb_mode & ovf;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wave_sample <= 7'h00;
        end else begin
            // preset templates bypass scaling entirely
            o_wave_sample <= arb_mode ? nxt_wave : 7'h00;
        end
    end

    // ------------------------------------------------------------
    // register file and waveform memory access
    // ------------------------------------------------------------
    wire       wr_ctrl  = i_reg_wr & (i_reg_addr == `LIF_OFS_WAVE_RAM_CTRL);
    wire       wr_data  = i_reg_wr & (i_reg_addr == `LIF_OFS_WAVE_RAM_DATA);
    wire       wr_stat  = i_reg_wr & (i_reg_addr == `LIF_OFS_INT_STATUS_1);
    wire [1:0] stat_set = {loss_set, ovf_set};
    wire [1:0] stat_clr = wr_stat ? i_reg_wdata[1:0] : 2'h0;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            std_ff      <= 1'b0;
            cfg0_ff     <= `LIF_RST_CFG0;
            tmpl_ff     <= `LIF_RST_TEMPLATE;
            scale_ff    <= `LIF_RST_SCALE;
            ram_addr_ff <= 6'h00;
            ram_rw_ff   <= 1'b0;
            ram_done_ff <= 1'b0;
            wval_ff     <= 7'h00;
            mask_ff     <= `LIF_RST_MASK;
            stat_ff     <= 2'h0;
            for (i = 0; i < 64; i = i + 1) begin
                ram_ff[i] <= 7'h00;
            end
        end else begin
            // set wins over a clear in the same cycle
            stat_ff <= (stat_ff & ~stat_clr) | stat_set;
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `LIF_OFS_GLOBAL_CONFIG:
                        std_ff   <= i_reg_wdata[`LIF_BIT_LINE_STD];
                    `LIF_OFS_TX_CONFIG_0:
                        cfg0_ff  <= i_reg_wdata[3:0];
                    `LIF_OFS_TX_CONFIG_1:
                        tmpl_ff  <= i_reg_wdata[3:0];
                    `LIF_OFS_TX_AMP_SCALE:
                        scale_ff <= i_reg_wdata[5:0];
                    `LIF_OFS_INT_MASK_1:
                        mask_ff  <= i_reg_wdata[1:0];
                    default: begin
                    end
                endcase
            end
            if (wr_ctrl) begin
                ram_addr_ff <= i_reg_wdata[5:0];
                ram_rw_ff   <= i_reg_wdata[`LIF_BIT_RAM_RW];
                ram_done_ff <= i_reg_wdata[`LIF_BIT_RAM_DONE];
            end else if (ram_done_ff) begin
                ram_done_ff <= 1'b0;
            end
            if (ram_done_ff && !ram_rw_ff) begin
                ram_ff[ram_addr_ff] <= wval_ff;
            end
            if (wr_data) begin
                wval_ff <= i_reg_wdata[6:0];
            end else if (ram_done_ff && ram_rw_ff) begin
                wval_ff <= ram_ff[ram_addr_ff];
            end
        end
    end

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `LIF_OFS_GLOBAL_CONFIG: o_reg_rdata <= {7'h00, std_ff};
                `LIF_OFS_TX_CONFIG_0:   o_reg_rdata <= {4'h0, cfg0_ff};
                `LIF_OFS_TX_CONFIG_1:   o_reg_rdata <= {4'h0, tmpl_ff};
                `LIF_OFS_TX_AMP_SCALE:  o_reg_rdata <= {2'h0, scale_ff};
                `LIF_OFS_WAVE_RAM_CTRL:
                    o_reg_rdata <= {ram_done_ff, ram_rw_ff, ram_addr_ff};
                `LIF_OFS_WAVE_RAM_DATA: o_reg_rdata <= {1'b0, wval_ff};
                `LIF_OFS_INT_MASK_1:    o_reg_rdata <= {6'h00, mask_ff};
                `LIF_OFS_INT_STATUS_1:  o_reg_rdata <= {6'h00, stat_ff};
                default:                o_reg_rdata <= 8'h00;
            endcase
        end
    end

    assign o_irq = |(stat_ff & mask_ff);

endmodule

`default_nettype wire

// File: sim/lif_tx_front_assertions.sv
// concurrent checks on the transmit front end ports
`timescale 1ns/1ps
`default_nettype none
module lif_tx_front_chk #(
    parameter SUBPHASE_CYCLES = 4
) (
    // clock, reset and register port
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    // straps and line side
    input wire logic [1:0] i_control_mode,
    input wire logic [3:0] i_pulse_template_select,
    input wire logic [1:0] i_path_mode_pins,
    input wire logic       o_line_pos,
    input wire logic       o_line_neg,
    input wire logic [6:0] o_wave_sample,
    input wire logic [3:0] o_template_select,
    input wire logic       o_line_standard,
    input wire logic [1:0] o_path_mode
);
    logic [1:0] since_rst_ff;
    logic [3:0] pins;
    logic [1:0] line;
    assign pins = i_pulse_template_select;
    assign line = {o_line_pos, o_line_neg};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // straps pass a two-stage sync, judge them once it has filled
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            since_rst_ff <= 2'h0;
        else if (since_rst_ff != 2'h3)
            since_rst_ff <= since_rst_ff + 2'h1;
    end
    sequence hw_settled;
        (since_rst_ff == 2'h3 && i_control_mode == 2'h0 && $stable(pins)
         && $stable(i_control_mode) && $stable(i_path_mode_pins))[*3];
    endsequence
    sequence ram_go;
        i_reg_wr && i_reg_addr == 8'h08 && i_reg_wdata[7];
    endsequence
    sequence rd_at(a);
        i_reg_rd && i_reg_addr == a;
    endsequence
    a_hw_standard: assert property (hw_settled |->
        o_line_standard == (pins[3:1] != 3'h0)) else $error("strap std");
    a_hw_template: assert property (hw_settled |->
        o_template_select == pins) else $error("strap template");
    a_hw_path: assert property (hw_settled |->
        o_path_mode == i_path_mode_pins) else $error("strap path mode");
    a_rail_excl: assert property (line != 2'h3)
        else $error("both line pulses high");
    a_line_hold: assert property ($changed(line) |=>
        $stable(line)[*6]) else $error("line symbol too short");
    a_wave_preset: assert property (
        (o_template_select[3:2] != 2'h3)[*4] |-> o_wave_sample == 7'h0)
        else $error("shaping without 11xx");
    a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without read");
    a_done_clear: assert property (ram_go ##2 rd_at(8'h08)
        |=> !o_reg_rdata[7]) else $error("done still set");
    a_status_rsvd: assert property (rd_at(8'h1a) |=>
        o_reg_rdata[7:2] == 6'h0) else $error("status reserved bits");
endmodule
bind lif_tx_front lif_tx_front_chk #(.SUBPHASE_CYCLES(SUBPHASE_CYCLES))
    u_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_control_mode(i_control_mode),
    .i_pulse_template_select(i_pulse_template_select),
    .i_path_mode_pins(i_path_mode_pins), .o_line_pos(o_line_pos),
    .o_line_neg(o_line_neg), .o_wave_sample(o_wave_sample),
    .o_template_select(o_template_select),
    .o_line_standard(o_line_standard), .o_path_mode(o_path_mode));
`default_nettype wire

// File: sim/lif_tx_src.sv
// line clock and rail data source standing in for the framer
`timescale 1ns/1ps
`default_nettype none
module lif_tx_src (
    // frame control from the bench
    input  wire logic i_run,
    input  wire logic i_pos,
    input  wire logic i_neg,
    // transmit interface
    output var  logic o_clk,
    output var  logic o_pos,
    output var  logic o_neg
);
    // clock runs only within frames, one bit per 160 ns
    initial begin
        o_clk = 1'b0;
        o_pos = 1'b0;
        o_neg = 1'b0;
        #3;
        forever begin
            if (i_run) begin
                o_clk = 1'b1;
                // data moves mid-high so either edge finds it settled
                #40;
                o_pos = i_pos;
                o_neg = i_neg;
                #40;
                o_clk = 1'b0;
                #80;
            end else begin
                // idle rails toggle so no stale level passes for data
                #10;
                o_pos = ~o_pos;
                o_neg = ~o_neg;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the transmit front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       i_clk, i_reset_n, i_reg_wr, i_reg_rd;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, seen, hw_view;
    logic [1:0] i_control_mode, i_path_mode_pins, o_path_mode;
    logic [3:0] i_pulse_template_select, o_template_select;
    logic [6:0] o_wave_sample;
    logic       o_line_pos, o_line_neg, o_line_standard, o_term_internal;
    logic       o_irq, tx_clk, tx_p, tx_n, src_run, src_p, src_n;
    int         mismatches, tests_run, np, nn, nw;
    assign seen = {5'h0, nw != 0, np != 0, nn != 0};
    assign hw_view = {o_line_standard, o_term_internal, o_path_mode,
                      o_template_select};
    lif_tx_front #(.SUBPHASE_CYCLES(4)) DUT (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_tx_line_clock(tx_clk),
        .i_tx_data_positive(tx_p), .i_tx_data_negative(tx_n),
        .i_control_mode(i_control_mode),
        .i_pulse_template_select(i_pulse_template_select),
        .i_path_mode_pins(i_path_mode_pins), .o_line_pos(o_line_pos),
        .o_line_neg(o_line_neg), .o_wave_sample(o_wave_sample),
        .o_template_select(o_template_select), .o_irq(o_irq),
        .o_line_standard(o_line_standard), .o_path_mode(o_path_mode),
        .o_term_internal(o_term_internal));
    lif_tx_src SRC (.i_run(src_run), .i_pos(src_p), .i_neg(src_n),
        .o_clk(tx_clk), .o_pos(tx_p), .o_neg(tx_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    // one register cycle; a read compares masked data with d
    task automatic acc(input logic w, input logic [7:0] a, d, m);
        @(posedge i_clk);
        #1;
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = w;
        i_reg_rd = !w;
        @(posedge i_clk);
        #1;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        if (!w) chk(o_reg_rdata & m, d & m);
    endtask
    task automatic stream(input logic p, input logic n);
        @(posedge i_clk);
        #1;
        src_p = p;
        src_n = n;
        src_run = 1'b1;
        // old symbols drain from the eight-symbol pipeline first
        #2000;
        np = 0;
        nn = 0;
        nw = 0;
        repeat (400) begin
            #10;
            np += o_line_pos;
            nn += o_line_neg;
            nw += (o_wave_sample != 7'h0);
        end
        src_run = 1'b0;
    endtask
    task automatic t_regs();
        acc(1'b0, 8'h07, 8'h21, 8'h3f);
        acc(1'b1, 8'h03, 8'hff, 8'h00);
        acc(1'b0, 8'h03, 8'h00, 8'hff);
        acc(1'b1, 8'h06, 8'h01, 8'h00);
        acc(1'b0, 8'h06, 8'h01, 8'h0f);
        chk(hw_view & 8'h0f, 8'h01);
    endtask
    task automatic t_hw();
        @(posedge i_clk);
        #1;
        i_control_mode = 2'h0;
        i_path_mode_pins = 2'h2;
        i_pulse_template_select = 4'h1;
        #60;
        chk(hw_view, 8'h21);
        stream(1'b0, 1'b1);
        chk(seen, 8'h02);
        i_control_mode = 2'h1;
    endtask
    // {standard, negative seen, positive seen, neg rail, pos rail, cfg0}
    task automatic t_coding();
        logic [8:0] tbl [10] = '{9'h162, 9'h192, 9'h132, 9'h156, 9'h16a,
                                 9'h1f1, 9'h121, 9'h1e0, 9'h0e0, 9'h0d1};
        for (int i = 0; i < 10; i++) begin
            acc(1'b1, 8'h02, {7'h0, tbl[i][8]}, 8'h00);
            acc(1'b1, 8'h05, {4'h0, tbl[i][3:0]}, 8'h00);
            chk({7'h0, o_line_standard}, {7'h0, tbl[i][8]});
            stream(tbl[i][4], tbl[i][5]);
            chk(seen, {6'h0, tbl[i][6], tbl[i][7]});
        end
    endtask
    task automatic t_loss();
        #1000;
        acc(1'b0, 8'h1a, 8'h02, 8'h02);
        chk({7'h0, o_irq}, 8'h00);
        acc(1'b1, 8'h15, 8'h02, 8'h00);
        chk({7'h0, o_irq}, 8'h01);
        acc(1'b1, 8'h1a, 8'h02, 8'h00);
        acc(1'b0, 8'h1a, 8'h00, 8'h02);
        chk({7'h0, o_irq}, 8'h00);
    endtask
    task automatic t_ram();
        acc(1'b1, 8'h07, 8'h3f, 8'h00);
        for (int i = 0; i < 64; i++) begin
            acc(1'b1, 8'h09, 8'h3f, 8'h00);
            acc(1'b1, 8'h08, 8'h80 | 8'(i), 8'h00);
        end
        acc(1'b1, 8'h09, 8'h00, 8'h00);
        acc(1'b1, 8'h08, 8'he5, 8'h00);
        acc(1'b0, 8'h08, 8'h00, 8'h80);
        acc(1'b0, 8'h09, 8'h3f, 8'h7f);
        acc(1'b1, 8'h06, 8'h0c, 8'h00);
        acc(1'b1, 8'h05, 8'h02, 8'h00);
        acc(1'b1, 8'h15, 8'h01, 8'h00);
        stream(1'b0, 1'b1);
        chk(seen, 8'h06);
        acc(1'b0, 8'h1a, 8'h01, 8'h01);
        chk({7'h0, o_irq}, 8'h01);
        acc(1'b1, 8'h06, 8'h01, 8'h00);
        stream(1'b0, 1'b1);
        chk(seen, 8'h02);
    endtask
    task automatic give_verdict();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // traffic needs about 80 us; allow over seven times that
    initial begin
        #600000;
        mismatches++;
        give_verdict();
    end
    initial begin
        i_reset_n = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_control_mode = 2'h1;
        i_path_mode_pins = 2'h0;
        i_pulse_template_select = 4'h0;
        src_run = 1'b0;
        src_p = 1'b0;
        src_n = 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        t_regs();
        t_hw();
        t_coding();
        t_loss();
        t_ram();
        give_verdict();
    end
endmodule
`default_nettype wire
